// ==== rtl/charger_limit_threshold_regs.v ====
// charger duration, voltage set point and overcurrent threshold registers
`timescale 1ns/100ps
`include "charger_limit_threshold_defs.vh"

module charger_limit_threshold_regs
#(
    parameter TICK_CYCLES = `CYCLES_PER_US
)
(
    clock,
    rst_n,
    wrStrobe,
    rdStrobe,
    cmdCode,
    wrData,
    rdData,
    rdValid,
    debounceSel,
    holdSel,
    lowPowerThreshSel,
    platformPowerMonitorEn,
    adapterPresent,
    batteryPresent,
    charging,
    lowPowerMode,
    learnRequest,
    adapterCurrentMa,
    dischargeCurrentMa,
    batteryVoltageMv,
    firstLevelDurationUs,
    secondLevelDurationUs,
    chargeVoltageLimitMv,
    systemTargetMv,
    trickleMode,
    learnMode,
    refActive,
    throttleAlertOut,
    throttleAlertOe_n
);
    input  wire        clock;
    input  wire        rst_n;
    input  wire        wrStrobe;
    input  wire        rdStrobe;
    input  wire [7:0]  cmdCode;
    input  wire [15:0] wrData;
    output reg  [15:0] rdData;
    output reg         rdValid;
    input  wire [1:0]  debounceSel;
    input  wire [2:0]  holdSel;
    input  wire [1:0]  lowPowerThreshSel;
    input  wire        platformPowerMonitorEn;
    input  wire        adapterPresent;
    input  wire        batteryPresent;
    input  wire        charging;
    input  wire        lowPowerMode;
    input  wire        learnRequest;
    input  wire [15:0] adapterCurrentMa;
    input  wire [15:0] dischargeCurrentMa;
    input  wire [15:0] batteryVoltageMv;
    output reg  [15:0] firstLevelDurationUs;
    output reg  [15:0] secondLevelDurationUs;
    output reg  [15:0] chargeVoltageLimitMv;
    output reg  [15:0] systemTargetMv;
    output reg         trickleMode;
    output reg         learnMode;
    output reg         refActive;
    output reg         throttleAlertOut;
    output reg         throttleAlertOe_n;

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    reg rstMeta_r;
    reg rstSync_r;

    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end
        else
        begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end

    // ----------------------------------------------------------------
    // write conditioning
    // ----------------------------------------------------------------
    wire [10:0] voltField  = wrData[`VOLT_MSB:`VOLT_LSB];
    wire [5:0]  adaptField = wrData[`ADAPTER_OC_MSB:`ADAPTER_OC_LSB];
    wire [5:0]  dischField = wrData[`DISCHARGE_OC_MSB:`DISCHARGE_OC_LSB];

    // clamp in field units so the stored word is always a legal setting
    wire [10:0] voltClamp  = (voltField > `VOLT_FIELD_MAX) ? `VOLT_FIELD_MAX : voltField;
    wire [5:0]  adaptClamp = (adaptField > `ADAPTER_OC_FIELD_MAX) ? `ADAPTER_OC_FIELD_MAX : adaptField;
    wire [5:0]  dischClamp = (dischField > `DISCHARGE_OC_FIELD_MAX) ? `DISCHARGE_OC_FIELD_MAX : dischField;

    wire [15:0] voltWord  = {2'h0, voltClamp, 3'h0};
    wire [15:0] adaptWord = {3'h0, adaptClamp, 7'h00};
    wire [15:0] dischWord = {2'h0, dischClamp, 8'h00};

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg [15:0] duration_r;
    reg [15:0] upperVoltage_r;
    reg [15:0] lowerVoltage_r;
    reg [15:0] adapterOc_r;
    reg [15:0] dischargeOc_r;

    always @(posedge clock or negedge rstSync_r)
    begin
        if (!rstSync_r)
        begin
            duration_r     <= `RST_DURATION;
            upperVoltage_r <= `RST_UPPER_VOLTAGE;
            lowerVoltage_r <= `RST_LOWER_VOLTAGE;
            adapterOc_r    <= `RST_ADAPTER_OC;
            dischargeOc_r  <= `RST_DISCHARGE_OC;
        end
        else if (wrStrobe)
        begin
            case (cmdCode)
                `CMD_TWO_LEVEL_DURATION: duration_r     <= wrData & `DURATION_MASK;
                `CMD_UPPER_VOLTAGE:      upperVoltage_r <= voltWord;
                `CMD_LOWER_VOLTAGE:      lowerVoltage_r <= voltWord;
                `CMD_ADAPTER_OC:         adapterOc_r    <= adaptWord;
                `CMD_DISCHARGE_OC:       dischargeOc_r  <= dischWord;
                default:                 duration_r     <= duration_r;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // read back
    // ----------------------------------------------------------------
    reg [15:0] rdData_nxt;

    always @*
    begin
        case (cmdCode)
            `CMD_TWO_LEVEL_DURATION: rdData_nxt = duration_r;
            `CMD_UPPER_VOLTAGE:      rdData_nxt = upperVoltage_r;
            `CMD_LOWER_VOLTAGE:      rdData_nxt = lowerVoltage_r;
            `CMD_ADAPTER_OC:         rdData_nxt = adapterOc_r;
            `CMD_DISCHARGE_OC:       rdData_nxt = dischargeOc_r;
            default:                 rdData_nxt = 16'h0000;
        endcase
    end

    always @(posedge clock or negedge rstSync_r)
    begin
        if (!rstSync_r)
        begin
            rdData  <= 16'h0000;
            rdValid <= 1'b0;
        end
        else
        begin
            rdValid <= rdStrobe;
            if (rdStrobe)
                rdData <= rdData_nxt;
        end
    end

    // ----------------------------------------------------------------
    // duration decode
    // ----------------------------------------------------------------
    reg [15:0] firstUs_nxt;
    reg [15:0] secondUs_nxt;

    always @*
    begin
        case (duration_r[`FIRST_DUR_MSB:`FIRST_DUR_LSB])
            3'h0:    firstUs_nxt = `FIRST_DUR_US_0;
            3'h1:    firstUs_nxt = `FIRST_DUR_US_1;
            3'h2:    firstUs_nxt = `FIRST_DUR_US_2;
            3'h3:    firstUs_nxt = `FIRST_DUR_US_3;
            3'h4:    firstUs_nxt = `FIRST_DUR_US_4;
            3'h5:    firstUs_nxt = `FIRST_DUR_US_5;
            3'h6:    firstUs_nxt = `FIRST_DUR_US_6;
            default: firstUs_nxt = `FIRST_DUR_US_7;
        endcase
        case (duration_r[`SECOND_DUR_MSB:`SECOND_DUR_LSB])
            3'h0:    secondUs_nxt = `SECOND_DUR_US_0;
            3'h1:    secondUs_nxt = `SECOND_DUR_US_1;
            3'h2:    secondUs_nxt = `SECOND_DUR_US_2;
            3'h3:    secondUs_nxt = `SECOND_DUR_US_3;
            3'h4:    secondUs_nxt = `SECOND_DUR_US_4;
            3'h5:    secondUs_nxt = `SECOND_DUR_US_5;
            3'h6:    secondUs_nxt = `SECOND_DUR_US_6;
            default: secondUs_nxt = `SECOND_DUR_US_7;
        endcase
    end

    // ----------------------------------------------------------------
    // voltage targets and modes
    // ----------------------------------------------------------------
    // lower-than-upper ordering is left to software, nothing checks it
    wire belowLower = (batteryVoltageMv < lowerVoltage_r);
    wire trickle_nxt = batteryPresent & charging & belowLower;
    wire learn_nxt   = batteryPresent & learnRequest & ~belowLower;
    wire [15:0] target_nxt = trickle_nxt ? lowerVoltage_r : upperVoltage_r;

    // ----------------------------------------------------------------
    // alert thresholds
    // ----------------------------------------------------------------
    reg  [15:0] lpThreshMa;
    reg  [15:0] debounceUs;
    reg  [15:0] holdUs;

    always @*
    begin
        case (lowPowerThreshSel)
            2'h0:    lpThreshMa = `LP_DISCHARGE_MA_0;
            2'h1:    lpThreshMa = `LP_DISCHARGE_MA_1;
            2'h2:    lpThreshMa = `LP_DISCHARGE_MA_2;
            default: lpThreshMa = `LP_DISCHARGE_MA_3;
        endcase
        case (debounceSel)
            2'h0:    debounceUs = `DEBOUNCE_US_0;
            2'h1:    debounceUs = `DEBOUNCE_US_1;
            2'h2:    debounceUs = `DEBOUNCE_US_2;
            default: debounceUs = `DEBOUNCE_US_3;
        endcase
        case (holdSel)
            3'h0:    holdUs = `HOLD_US_0;
            3'h1:    holdUs = `HOLD_US_1;
            3'h2:    holdUs = `HOLD_US_2;
            3'h3:    holdUs = `HOLD_US_3;
            3'h4:    holdUs = `HOLD_US_4;
            3'h5:    holdUs = `HOLD_US_5;
            3'h6:    holdUs = `HOLD_US_6;
            default: holdUs = `HOLD_US_7;
        endcase
    end

    wire batteryOnly  = ~adapterPresent;
    wire refActive_nxt = adapterPresent | platformPowerMonitorEn;
    wire [15:0] dischThreshMa = (batteryOnly & lowPowerMode) ? lpThreshMa : dischargeOc_r;
    wire adapterOver  = adapterPresent & (adapterCurrentMa > adapterOc_r);
    wire dischOver    = refActive_nxt & (dischargeCurrentMa > dischThreshMa);

    // ----------------------------------------------------------------
    // microsecond tick
    // ----------------------------------------------------------------
    reg [15:0] tickCount_r;
    reg        tickUs_r;

    always @(posedge clock or negedge rstSync_r)
    begin
        if (!rstSync_r)
        begin
            tickCount_r <= 16'h0000;
            tickUs_r    <= 1'b0;
        end
        else if (tickCount_r >= TICK_CYCLES[15:0] - 16'h0001)
        begin
            tickCount_r <= 16'h0000;
            tickUs_r    <= 1'b1;
        end
        else
        begin
            tickCount_r <= tickCount_r + 16'h0001;
            tickUs_r    <= 1'b0;
        end
    end

    // one timer serves both causes, so they share debounce and hold
    wire alertRaw;

    throttle_alert_timer alertTimer
    (
        .clock      (clock),
        .rstSync_n  (rstSync_r),
        .tickUs     (tickUs_r),
        .overLimit  (adapterOver | dischOver),
        .debounceUs (debounceUs),
        .holdUs     (holdUs),
        .alert      (alertRaw)
    );

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    always @(posedge clock or negedge rstSync_r)
    begin
        if (!rstSync_r)
        begin
            firstLevelDurationUs  <= `FIRST_DUR_US_0;
            secondLevelDurationUs <= `SECOND_DUR_US_0;
            chargeVoltageLimitMv  <= `RST_UPPER_VOLTAGE;
            systemTargetMv        <= `RST_UPPER_VOLTAGE;
            trickleMode           <= 1'b0;
            learnMode             <= 1'b0;
            refActive             <= 1'b0;
            throttleAlertOut      <= 1'b0;
            throttleAlertOe_n     <= 1'b1;
        end
        else
        begin
            firstLevelDurationUs  <= firstUs_nxt;
            secondLevelDurationUs <= secondUs_nxt;
            chargeVoltageLimitMv  <= upperVoltage_r;
            systemTargetMv        <= target_nxt;
            trickleMode           <= trickle_nxt;
            learnMode             <= learn_nxt;
            refActive             <= refActive_nxt;
            throttleAlertOut      <= 1'b0;
            // open drain: pulled low only while the alert stands
            throttleAlertOe_n     <= ~alertRaw;
        end
    end

endmodule

// ==== inc/charger_limit_threshold_defs.vh ====
// constants for the charger limit and threshold register bank
`ifndef CHARGER_LIMIT_THRESHOLD_DEFS_VH
`define CHARGER_LIMIT_THRESHOLD_DEFS_VH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define CMD_UPPER_VOLTAGE      8'h15
`define CMD_TWO_LEVEL_DURATION 8'h38
`define CMD_LOWER_VOLTAGE      8'h3E
`define CMD_ADAPTER_OC         8'h47
`define CMD_DISCHARGE_OC       8'h48

// ----------------------------------------------------------------
// field positions and masks
// ----------------------------------------------------------------
`define FIRST_DUR_MSB     2
`define FIRST_DUR_LSB     0
`define SECOND_DUR_MSB    10
`define SECOND_DUR_LSB    8
`define DURATION_MASK     16'h0707
`define VOLT_MSB          13
`define VOLT_LSB          3
`define ADAPTER_OC_MSB    12
`define ADAPTER_OC_LSB    7
`define DISCHARGE_OC_MSB  13
`define DISCHARGE_OC_LSB  8

// ----------------------------------------------------------------
// clamp limits (field values)
// ----------------------------------------------------------------
`define VOLT_FIELD_MAX         11'h6C0
`define ADAPTER_OC_FIELD_MAX   6'h32
`define DISCHARGE_OC_FIELD_MAX 6'h32

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_DURATION      16'h0000
`define RST_UPPER_VOLTAGE 16'h0000
`define RST_LOWER_VOLTAGE 16'h0000
`define RST_ADAPTER_OC    16'h0C00
`define RST_DISCHARGE_OC  16'h1000

// ----------------------------------------------------------------
// duration selections in microseconds
// ----------------------------------------------------------------
`define FIRST_DUR_US_0    16'h2710
`define FIRST_DUR_US_1    16'h4E20
`define FIRST_DUR_US_2    16'h3A98
`define FIRST_DUR_US_3    16'h1388
`define FIRST_DUR_US_4    16'h03E8
`define FIRST_DUR_US_5    16'h01F4
`define FIRST_DUR_US_6    16'h0064
`define FIRST_DUR_US_7    16'h0000
`define SECOND_DUR_US_0   16'h000A
`define SECOND_DUR_US_1   16'h0064
`define SECOND_DUR_US_2   16'h01F4
`define SECOND_DUR_US_3   16'h03E8
`define SECOND_DUR_US_4   16'h012C
`define SECOND_DUR_US_5   16'h02EE
`define SECOND_DUR_US_6   16'h07D0
`define SECOND_DUR_US_7   16'h2710

// ----------------------------------------------------------------
// alert debounce and hold selections in microseconds
// ----------------------------------------------------------------
`define DEBOUNCE_US_0     16'h0007
`define DEBOUNCE_US_1     16'h0064
`define DEBOUNCE_US_2     16'h01F4
`define DEBOUNCE_US_3     16'h03E8
`define HOLD_US_0         16'h000A
`define HOLD_US_1         16'h0014
`define HOLD_US_2         16'h0032
`define HOLD_US_3         16'h0064
`define HOLD_US_4         16'h00C8
`define HOLD_US_5         16'h01F4
`define HOLD_US_6         16'h03E8
`define HOLD_US_7         16'h07D0

// ----------------------------------------------------------------
// low power discharge thresholds in milliamps
// ----------------------------------------------------------------
`define LP_DISCHARGE_MA_0 16'h0800
`define LP_DISCHARGE_MA_1 16'h1000
`define LP_DISCHARGE_MA_2 16'h1800
`define LP_DISCHARGE_MA_3 16'h2000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS     8
`define NS_PER_US         1000
`define CYCLES_PER_US     (`NS_PER_US / `CLK_PERIOD_NS)

`endif

// ==== rtl/throttle_alert_timer.v ====
// debounce and minimum hold timer for the throttle alert
`timescale 1ns/100ps

module throttle_alert_timer
(
    clock,
    rstSync_n,
    tickUs,
    overLimit,
    debounceUs,
    holdUs,
    alert
);
    input  wire        clock;
    input  wire        rstSync_n;
    input  wire        tickUs;
    input  wire        overLimit;
    input  wire [15:0] debounceUs;
    input  wire [15:0] holdUs;
    output reg         alert;

    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    localparam [1:0] ST_IDLE     = 2'h0;
    localparam [1:0] ST_DEBOUNCE = 2'h1;
    localparam [1:0] ST_HOLD     = 2'h2;

    reg [1:0]  state_r;
    reg [1:0]  state_nxt;
    reg [15:0] count_r;
    reg [15:0] count_nxt;

    always @*
    begin
        state_nxt = state_r;
        count_nxt = count_r;
        case (state_r)
            ST_IDLE:
            begin
                count_nxt = 16'h0000;
                if (overLimit)
                    state_nxt = (debounceUs == 16'h0000) ? ST_HOLD : ST_DEBOUNCE;
            end
            ST_DEBOUNCE:
            begin
                // a dip below the limit restarts the debounce
                if (!overLimit)
                    state_nxt = ST_IDLE;
                else if (count_r >= debounceUs)
                begin
                    state_nxt = ST_HOLD;
                    count_nxt = 16'h0000;
                end
                else if (tickUs)
                    count_nxt = count_r + 16'h0001;
            end
            ST_HOLD:
            begin
                // released only once the hold has run out and the cause is gone
                if (count_r >= holdUs)
                begin
                    if (!overLimit)
                        state_nxt = ST_IDLE;
                end
                else if (tickUs)
                    count_nxt = count_r + 16'h0001;
            end
            default:
            begin
                state_nxt = ST_IDLE;
                count_nxt = 16'h0000;
            end
        endcase
    end

    always @(posedge clock or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            state_r <= ST_IDLE;
            count_r <= 16'h0000;
            alert   <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            count_r <= count_nxt;
            alert   <= (state_nxt == ST_HOLD);
        end
    end

endmodule

// ==== testbench/charger_limit_threshold_checker.sv ====
// assertion checker for the charger limit and threshold register bank
`timescale 1ns/100ps
module charger_limit_threshold_checker
#(
    parameter TICK_CYCLES = 125
)
(
    input wire        clock,
    input wire        rst_n,
    input wire        rdStrobe,
    input wire        rdValid,
    input wire        adapterPresent,
    input wire        batteryPresent,
    input wire        charging,
    input wire        learnRequest,
    input wire        platformPowerMonitorEn,
    input wire [15:0] chargeVoltageLimitMv,
    input wire [15:0] systemTargetMv,
    input wire        trickleMode,
    input wire        learnMode,
    input wire        refActive,
    input wire        throttleAlertOut,
    input wire        throttleAlertOe_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ----
    // properties
    // ----
    a_read_answer: assert property (rdStrobe |=> rdValid) else $error("read not answered");
    a_read_single: assert property (!rdStrobe |=> !rdValid) else $error("stray read valid");
    a_alert_opendrain: assert property (throttleAlertOut == 1'b0) else $error("alert drives high");
    a_volt_clamp: assert property (chargeVoltageLimitMv <= 16'h3600) else $error("voltage over clamp");
    a_target_upper: assert property (!trickleMode |-> systemTargetMv == chargeVoltageLimitMv)
        else $error("target not upper value");
    a_trickle_cause: assert property (trickleMode |-> $past(batteryPresent && charging))
        else $error("trickle without charging battery");
    a_learn_cause: assert property (learnMode |-> $past(batteryPresent && learnRequest))
        else $error("learn without request");
    a_mode_exclusive: assert property (!(trickleMode && learnMode)) else $error("both modes");
    a_ref_cause: assert property (refActive |-> $past(adapterPresent || platformPowerMonitorEn))
        else $error("reference active without cause");
    a_alert_source: assert property ($fell(throttleAlertOe_n) |-> $past(adapterPresent || platformPowerMonitorEn, 2))
        else $error("alert without source");
    // hold is at least ten ticks, so eight cycles is safe at any tick rate
    a_alert_hold: assert property ($fell(throttleAlertOe_n) |-> !throttleAlertOe_n [*8])
        else $error("alert released early");
    c_read: cover property (rdValid);
    c_alert: cover property ($fell(throttleAlertOe_n));
    c_trickle: cover property (trickleMode);
endmodule

// ==== testbench/host_model.sv ====
// host model issuing register writes and reads on the strobe port
`timescale 1ns/100ps
module host_model
(
    input  wire        clock,
    output reg         wrStrobe,
    output reg         rdStrobe,
    output reg  [7:0]  cmdCode,
    output reg  [15:0] wrData,
    input  wire [15:0] rdData,
    input  wire        rdValid
);
    initial
    begin
        {wrStrobe, rdStrobe, cmdCode, wrData} = 26'h0000000;
    end
    // lines are inverted once taken so stale values never look valid
    task wr(input [7:0] c, input [15:0] d);
    begin
        @(posedge clock);
        #1;
        cmdCode = c;
        wrData = d;
        wrStrobe = 1'b1;
        @(posedge clock);
        #1;
        wrStrobe = 1'b0;
        cmdCode = ~c;
        wrData = ~d;
    end
    endtask
    task rd(input [7:0] c, output [15:0] d, output ok);
        integer i;
    begin
        ok = 1'b0;
        d = 16'hXXXX;
        @(posedge clock);
        #1;
        cmdCode = c;
        rdStrobe = 1'b1;
        @(posedge clock);
        #1;
        rdStrobe = 1'b0;
        cmdCode = ~c;
        for (i = 0; i < 3 && !ok; i = i + 1)
        begin
            if (rdValid === 1'b1)
            begin
                d = rdData;
                ok = 1'b1;
            end
            @(posedge clock);
            #1;
        end
    end
    endtask
endmodule

// ==== testbench/charger_limit_threshold_regs_tb.sv ====
// self-checking testbench for the charger limit and threshold register bank
`timescale 1ns/100ps
module charger_limit_threshold_regs_tb;
    localparam [127:0] FIRST_US = {16'h0000, 16'h0064, 16'h01F4, 16'h03E8, 16'h1388, 16'h3A98, 16'h4E20, 16'h2710};
    localparam [127:0] SECOND_US = {16'h2710, 16'h07D0, 16'h02EE, 16'h012C, 16'h03E8, 16'h01F4, 16'h0064, 16'h000A};
    localparam [63:0]  DEB_US = {16'h03E8, 16'h01F4, 16'h0064, 16'h0007};
    localparam [127:0] HOLD_US = {16'h07D0, 16'h03E8, 16'h01F4, 16'h00C8, 16'h0064, 16'h0032, 16'h0014, 16'h000A};
    reg         clock;
    reg         rst_n;
    reg  [1:0]  debounceSel;
    reg  [2:0]  holdSel;
    reg  [1:0]  lowPowerThreshSel;
    reg         platformPowerMonitorEn;
    reg         adapterPresent;
    reg         batteryPresent;
    reg         charging;
    reg         lowPowerMode;
    reg         learnRequest;
    reg  [15:0] adapterCurrentMa;
    reg  [15:0] dischargeCurrentMa;
    reg  [15:0] batteryVoltageMv;
    wire        wrStrobe;
    wire        rdStrobe;
    wire [7:0]  cmdCode;
    wire [15:0] wrData;
    wire [15:0] rdData;
    wire        rdValid;
    wire [15:0] firstLevelDurationUs;
    wire [15:0] secondLevelDurationUs;
    wire [15:0] chargeVoltageLimitMv;
    wire [15:0] systemTargetMv;
    wire        trickleMode;
    wire        learnMode;
    wire        refActive;
    wire        throttleAlertOut;
    wire        throttleAlertOe_n;
    integer     n_mismatch;
    integer     compares;
    integer     k;
    integer     t;
    reg  [15:0] d;
    reg         ok;
    // tick of one clock keeps every alert time short
    charger_limit_threshold_regs #(.TICK_CYCLES(1)) i_charger_limit_threshold_regs (.*);
    host_model i_host_model (.*);
    initial clock = 1'b0;
    always #4 clock = ~clock;
    // ----
    // tasks
    // ----
    task test_done;
    begin
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    task check(input [127:0] name, input [15:0] exp, input [15:0] got);
    begin
        compares = compares + 1;
        if (got !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH %0s expected %h seen %h", name, exp, got);
        end
    end
    endtask
    task rdchk(input [7:0] c, input [15:0] exp);
    begin
        i_host_model.rd(c, d, ok);
        if (!ok)
        begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH read valid expected 1 seen 0");
            test_done;
        end
        else
            check("register read", exp, d);
    end
    endtask
    task wrchk(input [7:0] c, input [15:0] w, input [15:0] exp);
    begin
        i_host_model.wr(c, w);
        rdchk(c, exp);
    end
    endtask
    task waitOe(input lvl, input integer lo, input integer hi);
    begin
        t = 0;
        while (throttleAlertOe_n !== lvl && t <= hi)
        begin
            @(posedge clock);
            #1;
            t = t + 1;
        end
        compares = compares + 1;
        if (lo > hi ? t <= hi : (t < lo || t > hi)) // lo above hi: no edge allowed within hi cycles
        begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH alert delay expected %0d to %0d seen %0d", lo, hi, t);
            if (t > hi)
                test_done;
        end
    end
    endtask
    // ----
    // sequence
    // ----
    initial
    begin
        {n_mismatch, compares, rst_n, debounceSel, holdSel, lowPowerThreshSel} = 0;
        {platformPowerMonitorEn, adapterPresent, batteryPresent, charging, lowPowerMode, learnRequest} = 6'h00;
        {adapterCurrentMa, dischargeCurrentMa, batteryVoltageMv} = 48'h0;
        repeat (16) @(posedge clock);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge clock);
        check("first duration", 16'h2710, firstLevelDurationUs);
        check("second duration", 16'h000A, secondLevelDurationUs);
        rdchk(8'h38, 16'h0000);
        rdchk(8'h15, 16'h0000);
        rdchk(8'h3E, 16'h0000);
        rdchk(8'h47, 16'h0C00);
        rdchk(8'h48, 16'h1000);
        rdchk(8'h3F, 16'h0000);
        $display("test reset values done");
        wrchk(8'h38, 16'hFFFF, 16'h0707);
        wrchk(8'h15, 16'h3608, 16'h3600);
        wrchk(8'h3E, 16'hFFFF, 16'h3600);
        wrchk(8'h47, 16'h1980, 16'h1900);
        wrchk(8'h48, 16'hFFFF, 16'h3200);
        wrchk(8'h38, 16'hA5A5, 16'h0505);
        wrchk(8'h15, 16'hC1FF, 16'h01F8);
        check("voltage limit", 16'h01F8, chargeVoltageLimitMv);
        wrchk(8'h3E, 16'h8FFF, 16'h0FF8);
        wrchk(8'h47, 16'hEA5A, 16'h0A00);
        wrchk(8'h48, 16'hEBCD, 16'h2B00);
        wrchk(8'h3F, 16'hFFFF, 16'h0000);
        $display("test masking and clamp done");
        for (k = 0; k < 8; k = k + 1)
        begin
            i_host_model.wr(8'h38, {5'h00, k[2:0], 5'h00, k[2:0]});
            repeat (2) @(posedge clock);
            #1;
            check("first duration", FIRST_US[k*16 +: 16], firstLevelDurationUs);
            check("second duration", SECOND_US[k*16 +: 16], secondLevelDurationUs);
        end
        $display("test durations done");
        wrchk(8'h15, 16'h3000, 16'h3000);
        wrchk(8'h3E, 16'h2000, 16'h2000);
        {batteryPresent, charging, batteryVoltageMv} = {2'h3, 16'h1000};
        repeat (3) @(posedge clock);
        #1;
        check("trickle", 16'h0001, {15'h0000, trickleMode});
        check("target", 16'h2000, systemTargetMv);
        {learnRequest, batteryVoltageMv} = {1'b1, 16'h2000};
        repeat (3) @(posedge clock);
        #1;
        check("trickle", 16'h0000, {15'h0000, trickleMode});
        check("learn", 16'h0001, {15'h0000, learnMode});
        check("target", 16'h3000, systemTargetMv);
        {batteryPresent, charging, learnRequest} = 3'h0;
        $display("test modes done");
        {adapterPresent, adapterCurrentMa} = {1'b1, 16'h0A00};
        waitOe(1'b0, 31, 30);
        for (k = 0; k < 8; k = k + 1)
        begin
            debounceSel = k[1:0];
            holdSel = k[2:0];
            adapterCurrentMa = 16'h0A01;
            waitOe(1'b0, DEB_US[(k%4)*16 +: 16], DEB_US[(k%4)*16 +: 16] + 6);
            adapterCurrentMa = 16'h0A00;
            waitOe(1'b1, HOLD_US[k*16 +: 16], HOLD_US[k*16 +: 16] + 6);
        end
        $display("test adapter alert done");
        {adapterPresent, platformPowerMonitorEn, debounceSel, holdSel} = {2'h1, 5'h00};
        dischargeCurrentMa = 16'h2B01;
        waitOe(1'b0, 7, 13);
        {platformPowerMonitorEn, dischargeCurrentMa} = {1'b0, 16'h2B00};
        waitOe(1'b1, 10, 16);
        dischargeCurrentMa = 16'h2B01;
        waitOe(1'b0, 31, 30);
        check("reference", 16'h0000, {15'h0000, refActive});
        adapterPresent = 1'b1;
        waitOe(1'b0, 7, 13);
        check("reference", 16'h0001, {15'h0000, refActive});
        {adapterPresent, platformPowerMonitorEn, lowPowerMode, dischargeCurrentMa} = {3'h3, 16'h0000};
        waitOe(1'b1, 0, 16);
        // low power thresholds sit well under the register value, so a register-based compare stays silent
        for (k = 0; k < 4; k = k + 1)
        begin
            lowPowerThreshSel = k[1:0];
            dischargeCurrentMa = (k + 1) * 2048;
            waitOe(1'b0, 31, 30);
            dischargeCurrentMa = (k + 1) * 2048 + 1;
            waitOe(1'b0, 7, 13);
            dischargeCurrentMa = 16'h0000;
            waitOe(1'b1, 10, 16);
        end
        $display("test discharge alert done");
        test_done;
    end
endmodule
bind charger_limit_threshold_regs charger_limit_threshold_checker #(.TICK_CYCLES(TICK_CYCLES)) i_checker (.*);
